// *** hw/scrd_pkg.sv ***
package scrd_pkg;
  // Command byte layout
  localparam int unsigned CMD_WIDTH        = 8;
  localparam int unsigned CMD_GATE_BIT     = 7;
  localparam int unsigned CMD_MODE_HI_BIT  = 5;
  localparam int unsigned CMD_MODE_LO_BIT  = 4;
  localparam int unsigned CMD_SEL_MSB      = 2;
  localparam int unsigned CMD_SEL_LSB      = 0;
  localparam logic [7:0]  CMD_STOP_CONT    = 8'h30;
  localparam logic [7:0]  CMD_RESET_VAL    = 8'h00;
  localparam logic [2:0]  CMD_OFFSET       = 3'h0;

  // Transfer modes
  localparam logic [1:0]  MODE_WRITE       = 2'h0;
  localparam logic [1:0]  MODE_READ        = 2'h1;
  localparam logic [1:0]  MODE_CONT_START  = 2'h2;
  localparam logic [1:0]  MODE_CONT_STOP   = 2'h3;

  // Target select codes
  localparam logic [2:0]  SEL_CMD_STATUS   = 3'h0;
  localparam logic [2:0]  SEL_DATA         = 3'h1;
  localparam logic [2:0]  SEL_MODE         = 3'h2;
  localparam logic [2:0]  SEL_FILTER       = 3'h3;
  localparam logic [2:0]  SEL_NONE         = 3'h4;
  localparam logic [2:0]  SEL_OFFSET       = 3'h5;
  localparam logic [2:0]  SEL_GAIN         = 3'h6;
  localparam logic [2:0]  SEL_TEST         = 3'h7;

  // Interface reset and timing
  localparam int unsigned RESET_ONES       = 32;
  localparam int unsigned HOST_CLK_DIV     = 6;
  localparam int unsigned MAX_XFER_BITS    = 24;

  typedef enum logic [3:0] {
    SCRD_IDLE = 4'b0001,
    SCRD_CMD  = 4'b0010,
    SCRD_XFER = 4'b0100,
    SCRD_CONT = 4'b1000
  } scrd_state_e;
endpackage : scrd_pkg

// *** hw/scrd_link_if.sv ***
`timescale 1ns/1ps
interface scrd_link_if;
  logic sclk;
  logic din;
  logic dout;
  modport host   (output sclk, output din, input dout);
  modport device (input sclk, input din, output dout);
endinterface : scrd_link_if

// *** hw/scrd_sync_edge.sv ***
`timescale 1ns/1ps
module scrd_sync_edge (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic sclk_in,
  input  wire logic din_in,
  output logic      rise_q,
  output logic      fall_q,
  output logic      din_q
);
  logic [1:0] sclk_sync_q;
  logic [1:0] din_sync_q;
  logic       sclk_last_q;

  // ----------------------------------------
  // Two-stage synchronisers, edge finding
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sync_q <= 2'h0;
      din_sync_q  <= 2'h0;
      sclk_last_q <= 1'b0;
      rise_q      <= 1'b0;
      fall_q      <= 1'b0;
      din_q       <= 1'b0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], sclk_in};
      din_sync_q  <= {din_sync_q[0], din_in};
      sclk_last_q <= sclk_sync_q[1];
      rise_q      <= sclk_sync_q[1] & ~sclk_last_q;
      fall_q      <= ~sclk_sync_q[1] & sclk_last_q;
      din_q       <= din_sync_q[1];
    end
  end
endmodule : scrd_sync_edge

// *** hw/scrd_device.sv ***
`timescale 1ns/1ps
//
// Overview of operation
// - Transactions start with the command byte.
// - Single transfer done, return to idle.
// - Reset leaves interface idle awaiting command.
// - 32 ones on data input reset.
// - Command shifted most significant bit first.
// - Stay on gate bit until zero.
// - Host sends zero in bits 6, 3.
// - Mode 00 means single write.
// - Mode 01 means single read.
// - Mode 10 starts continuous read.
// - Only 0x30, the 32-ones reset or rst_b ends continuous read.
// - Continuous read keeps sampling data input.
// - Host holds data low during continuous.
// - Bits 2..0 select target register.
// - Code 000: command write, status read.
// - Other codes map; 100 accesses nothing.
//
module scrd_device
  import scrd_pkg::*;
#(
  parameter int unsigned DATA_BITS = 24
) (
  scrd_link_if.device   link,
  output logic [2:0]    target_select_field_q,
  output logic          transfer_mode_high_q,
  output logic          transfer_mode_low_q,
  output logic [23:0]   wr_data_q,
  output logic          wr_strobe_q,
  output logic          rd_strobe_q,
  output logic          cont_active_q,
  output logic          iface_reset_q,
  input  wire logic [23:0] rd_data,
  input  wire logic [4:0]  rd_len,
  input  wire logic        clk_sys,
  input  wire logic        rst_b
);
  initial begin
    if (DATA_BITS != MAX_XFER_BITS) begin
      $error("DATA_BITS must be 24");
    end
  end

  logic        rise;
  logic        fall;
  logic        din_s;
  scrd_state_e state_q;
  logic [7:0]  shift_q;
  logic [4:0]  bit_cnt_q;
  logic [4:0]  xfer_len_q;
  logic [5:0]  ones_q;
  logic [23:0] out_q;
  logic        rd_phase_q;
  logic        dout_q;
  logic [7:0]  cmd_d;
  logic [4:0]  len_d;
  logic        ones_hit;

  scrd_sync_edge u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .sclk_in (link.sclk),
    .din_in  (link.din),
    .rise_q  (rise),
    .fall_q  (fall),
    .din_q   (din_s)
  );

  assign link.dout = dout_q;
  assign cmd_d     = {shift_q[6:0], din_s};
  assign ones_hit  = rise && din_s && (ones_q == 6'(RESET_ONES - 1));

  // ----------------------------------------
  // Transfer length decode
  // ----------------------------------------
  // Length per target; 100 moves no bits, status and command are a byte
  always_comb begin
    case (cmd_d[CMD_SEL_MSB:CMD_SEL_LSB])
      SEL_NONE:       len_d = 5'h0;
      SEL_CMD_STATUS: len_d = 5'h8;
      default:        len_d = rd_len;
    endcase
  end

  // ----------------------------------------
  // Run of ones detector
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ones_q        <= 6'h0;
      iface_reset_q <= 1'b0;
    end else begin
      iface_reset_q <= ones_hit;
      // Counted per serial edge, so the host's speed does not matter
      if (rise) begin
        if (!din_s || ones_hit) ones_q <= 6'h0;
        else ones_q <= ones_q + 6'h1;
      end
    end
  end

  // ----------------------------------------
  // Command and transfer sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q               <= SCRD_IDLE;
      shift_q               <= CMD_RESET_VAL;
      bit_cnt_q             <= 5'h0;
      xfer_len_q            <= 5'h0;
      target_select_field_q <= 3'h0;
      transfer_mode_high_q  <= 1'b0;
      transfer_mode_low_q   <= 1'b0;
      wr_data_q             <= 24'h0;
      wr_strobe_q           <= 1'b0;
      rd_strobe_q           <= 1'b0;
      cont_active_q         <= 1'b0;
      rd_phase_q            <= 1'b0;
      out_q                 <= 24'h0;
    end else begin
      wr_strobe_q <= 1'b0;
      rd_strobe_q <= 1'b0;
      if (ones_hit) begin
        state_q       <= SCRD_IDLE;
        cont_active_q <= 1'b0;
        rd_phase_q    <= 1'b0;
      end else if (rise) begin
        case (state_q)
          SCRD_IDLE: begin
            // Gate bit must be zero before anything counts
            if (!din_s) begin
              state_q   <= SCRD_CMD;
              bit_cnt_q <= 5'h0;
              shift_q   <= CMD_RESET_VAL;
            end
          end
          SCRD_CMD: begin
            shift_q   <= cmd_d;
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == 5'h6) begin
              target_select_field_q <= cmd_d[CMD_SEL_MSB:CMD_SEL_LSB];
              transfer_mode_high_q  <= cmd_d[CMD_MODE_HI_BIT];
              transfer_mode_low_q   <= cmd_d[CMD_MODE_LO_BIT];
              bit_cnt_q             <= 5'h0;
              xfer_len_q            <= len_d;
              case (cmd_d[CMD_MODE_HI_BIT:CMD_MODE_LO_BIT])
                MODE_WRITE, MODE_READ: begin
                  state_q    <= (len_d == 5'h0) ? SCRD_IDLE : SCRD_XFER;
                  rd_phase_q <= cmd_d[CMD_MODE_LO_BIT];
                  rd_strobe_q <= cmd_d[CMD_MODE_LO_BIT] && len_d != 5'h0;
                  out_q      <= rd_data << (5'd24 - len_d);
                end
                MODE_CONT_START: begin
                  state_q       <= SCRD_CONT;
                  cont_active_q <= 1'b1;
                  rd_phase_q    <= 1'b1;
                  rd_strobe_q   <= 1'b1;
                  out_q         <= rd_data << (5'd24 - len_d);
                end
                default: state_q <= SCRD_IDLE; // Stop outside continuous
              endcase
            end
          end
          SCRD_XFER: begin
            // Write data lands msb first; only the low xfer_len bits count
            wr_data_q <= {wr_data_q[22:0], din_s};
            bit_cnt_q <= bit_cnt_q + 5'h1;
            if (bit_cnt_q == xfer_len_q - 5'h1) begin
              state_q     <= SCRD_IDLE;
              rd_phase_q  <= 1'b0;
              wr_strobe_q <= ~rd_phase_q;
            end
          end
          SCRD_CONT: begin
            // Data input watched every edge for the stop byte
            shift_q   <= cmd_d;
            bit_cnt_q <= (bit_cnt_q == xfer_len_q - 5'h1) ? 5'h0
                         : bit_cnt_q + 5'h1;
            if (bit_cnt_q == xfer_len_q - 5'h1) begin
              rd_strobe_q <= 1'b1;
              out_q       <= rd_data << (5'd24 - xfer_len_q);
            end
            if (cmd_d == CMD_STOP_CONT) begin
              state_q       <= SCRD_IDLE;
              cont_active_q <= 1'b0;
              rd_phase_q    <= 1'b0;
            end
          end
          default: state_q <= SCRD_IDLE;
        endcase
      end else if (fall && rd_phase_q && state_q != SCRD_CMD) begin
        // Launch on the far edge leaves the host a full high phase
        out_q <= {out_q[22:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Serial output, changes on falling edge
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) dout_q <= 1'b0;
    else if (fall) dout_q <= rd_phase_q & out_q[23];
  end
endmodule : scrd_device

// *** hw/scrd_host.sv ***
`timescale 1ns/1ps
module scrd_host
  import scrd_pkg::*;
#(
  parameter int unsigned DIV = HOST_CLK_DIV
) (
  scrd_link_if.host   link,
  input  wire logic        start,
  input  wire logic [5:0]  nbits,
  input  wire logic [31:0] tx_word,
  output logic        busy_q,
  output logic        done_q,
  output logic [31:0] rx_word_q,
  input  wire logic        clk_sys,
  input  wire logic        rst_b
);
  initial begin
    if (DIV < 2) $error("DIV must be at least 2");
  end

  logic [7:0]  div_q;
  logic [5:0]  left_q;
  logic [31:0] tx_q;
  logic        sclk_q;
  logic        din_q;
  logic [1:0]  dout_sync_q;

  assign link.sclk = sclk_q;
  assign link.din  = din_q;

  // ----------------------------------------
  // Frame engine; data changes while clock low
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q       <= 8'h0;
      left_q      <= 6'h0;
      tx_q        <= 32'h0;
      sclk_q      <= 1'b0;
      din_q       <= 1'b0;
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      rx_word_q   <= 32'h0;
      dout_sync_q <= 2'h0;
    end else begin
      dout_sync_q <= {dout_sync_q[0], link.dout};
      done_q      <= 1'b0;
      if (!busy_q) begin
        // Idle with data low keeps a continuous read undisturbed
        din_q <= 1'b0;
        if (start && nbits != 6'h0) begin
          busy_q <= 1'b1;
          left_q <= nbits;
          // Msb first on the wire; caller keeps bits 6, 3 of a command zero
          tx_q   <= tx_word << (6'd32 - nbits);
          div_q  <= 8'h0;
        end
      end else if (div_q == 8'(DIV - 1)) begin
        div_q <= 8'h0;
        if (!sclk_q) begin
          sclk_q <= 1'b1;
        end else begin
          // Sampled at the end of the high phase: the device launches
          // read data a few cycles after each fall, behind its synchroniser
          sclk_q    <= 1'b0;
          rx_word_q <= {rx_word_q[30:0], dout_sync_q[1]};
          left_q    <= left_q - 6'h1;
          if (left_q == 6'h1) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end else begin
        div_q <= div_q + 8'h1;
        if (!sclk_q && div_q == 8'h0) begin
          din_q <= tx_q[31];
          tx_q  <= {tx_q[30:0], 1'b0};
        end
      end
    end
  end
endmodule : scrd_host

// *** sim/scrd_props.sv ***
`timescale 1ns/1ps
module scrd_props (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic dout,
  input  wire logic cont_active_q,
  input  wire logic iface_reset_q,
  input  wire logic wr_strobe_q
);
  // --------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------
  logic       sclk_p_q;
  logic [5:0] ones_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) sclk_p_q <= 1'b0;
    else sclk_p_q <= sclk;
  end

  // Raw pin view runs ahead of the device's synchroniser
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) ones_q <= 6'h00;
    else if (sclk && !sclk_p_q) ones_q <= !din ? 6'h00 :
                                          (ones_q == 6'h3f) ? ones_q :
                                          ones_q + 6'h01;
  end

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_high_phase;
    sclk [*6] ##1 !sclk;
  endsequence

  a_dout_holds_high: assert property (sclk && sclk_p_q |-> $stable(dout))
    else $error("read data moved while serial clock high");
  a_din_holds_high: assert property (sclk && sclk_p_q |-> $stable(din))
    else $error("host data moved while serial clock high");
  a_sclk_high_len: assert property ($rose(sclk) |-> s_high_phase)
    else $error("serial clock high phase length wrong");
  a_idle_after_reset: assert property ($rose(rst_b) |-> !cont_active_q && !sclk)
    else $error("interface not idle after reset");
  a_reset_needs_ones: assert property ($rose(iface_reset_q) |-> ones_q >= 6'h20)
    else $error("interface reset without enough ones");
  a_reset_pulse_once: assert property (iface_reset_q |=> !iface_reset_q)
    else $error("interface reset pulse too long");
  a_reset_ends_cont: assert property (iface_reset_q |-> ##[0:2] !cont_active_q)
    else $error("continuous read survived interface reset");
  a_write_pulse_once: assert property (wr_strobe_q |=> !wr_strobe_q)
    else $error("write strobe too long");
endmodule : scrd_props

// *** sim/serial_command_register_decoder_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  cmp_count++; \
  if ((e) !== (g)) begin \
    $display("ERROR %s exp %h got %h", nm, e, g); \
    err_total++; \
  end
module serial_command_register_decoder_bench import scrd_pkg::*;;
  logic        clk_sys, rst_b, start, busy_q, done_q;
  logic [5:0]  nbits;
  logic [31:0] tx_word, rx_word_q, msk;
  logic [2:0]  target_select_field_q;
  logic        transfer_mode_high_q, transfer_mode_low_q;
  logic [23:0] wr_data_q, rd_data;
  logic        wr_strobe_q, rd_strobe_q, cont_active_q, iface_reset_q;
  logic [4:0]  rd_len;
  logic [15:0] seed;
  logic [15:0] exp_wr[$];
  int          err_total, cmp_count, wr_cnt, rst_cnt, rd_cnt, n0, s, len;

  scrd_link_if link ();
  scrd_host #(.DIV(HOST_CLK_DIV)) i_scrd_host (.link(link), .start(start),
    .nbits(nbits), .tx_word(tx_word), .busy_q(busy_q), .done_q(done_q),
    .rx_word_q(rx_word_q), .clk_sys(clk_sys), .rst_b(rst_b));
  scrd_device #(.DATA_BITS(24)) i_scrd_device (.link(link),
    .target_select_field_q(target_select_field_q),
    .transfer_mode_high_q(transfer_mode_high_q),
    .transfer_mode_low_q(transfer_mode_low_q), .wr_data_q(wr_data_q),
    .wr_strobe_q(wr_strobe_q), .rd_strobe_q(rd_strobe_q),
    .cont_active_q(cont_active_q), .iface_reset_q(iface_reset_q),
    .rd_data(rd_data), .rd_len(rd_len), .clk_sys(clk_sys), .rst_b(rst_b));
  scrd_props i_scrd_props (.clk_sys(clk_sys), .rst_b(rst_b),
    .sclk(link.sclk), .din(link.din), .dout(link.dout),
    .cont_active_q(cont_active_q), .iface_reset_q(iface_reset_q),
    .wr_strobe_q(wr_strobe_q));

  // --------------------------------------------------------------
  // Clock, monitor and helpers
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Away from the launching edge, so strobes are seen exactly once
  always @(negedge clk_sys) begin
    if (iface_reset_q === 1'b1) rst_cnt++;
    if (rd_strobe_q === 1'b1) rd_cnt++;
    if (wr_strobe_q === 1'b1) begin
      wr_cnt++;
      if (exp_wr.size() != 0) begin
        `CHK("wr_data", exp_wr[0], wr_data_q[15:0])
        void'(exp_wr.pop_front());
      end
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic xfer(input int n, input logic [31:0] w);
    int k;
    @(posedge clk_sys);
    #1 start = 1'b1;
    nbits = 6'(n);
    tx_word = w;
    @(posedge clk_sys);
    #1 start = 1'b0;
    for (k = 0; k < 1000 && done_q !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (k == 1000) err_total++;
  endtask : xfer

  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Span well beyond the full sequence of transfers
  initial begin
    #500000;
    err_total++;
    end_sim();
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    nbits = 6'h00;
    tx_word = 32'h0;
    rd_data = 24'h0;
    rd_len = 5'h10;
    seed = 16'h0023;
    repeat (6) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    `CHK("idle", 1'b0, cont_active_q)
    n0 = rd_cnt;
    for (s = 0; s < 8; s++) begin
      seed = lfsr(seed);
      rd_data = {seed[7:0], seed};
      len = (s == 0) ? 8 : ((s == 4) ? 0 : ((s > 4) ? 24 : 16));
      rd_len = (len == 24) ? 5'h18 : 5'h10;
      msk = (32'h1 << len) - 32'h1;
      xfer(8 + len, 32'(8'h10 | 8'(s)) << len);
      `CHK("sel", 3'(s), target_select_field_q)
      `CHK("mode", 2'h1, {transfer_mode_high_q, transfer_mode_low_q})
      `CHK("rd", 32'(rd_data) & msk, rx_word_q & msk)
    end
    `CHK("rd_cnt", n0 + 7, rd_cnt)
    rd_len = 5'h10;
    $display("test single reads done");
    seed = lfsr(seed);
    exp_wr.push_back(seed);
    n0 = wr_cnt;
    xfer(27, {5'h00, 3'h7, 8'h02, seed});
    `CHK("wr_cnt", n0 + 1, wr_cnt)
    `CHK("wr_left", 0, exp_wr.size())
    `CHK("mode", 2'h0, {transfer_mode_high_q, transfer_mode_low_q})
    $display("test gated write done");
    seed = lfsr(seed);
    rd_data = {8'h00, seed};
    xfer(8, 32'h21);
    `CHK("cont_on", 1'b1, cont_active_q)
    n0 = rd_cnt;
    repeat (2) begin
      xfer(16, 32'h0);
      `CHK("cont_rd", rd_data[15:0], rx_word_q[15:0])
    end
    `CHK("rd_cnt", n0 + 2, rd_cnt)
    xfer(8, 32'h30);
    `CHK("cont_off", 1'b0, cont_active_q)
    xfer(8, 32'h30);
    `CHK("stop", 2'h3, {transfer_mode_high_q, transfer_mode_low_q})
    xfer(16, 32'h1000);
    `CHK("status", rd_data[7:0], rx_word_q[7:0])
    $display("test continuous read done");
    xfer(8, 32'h21);
    n0 = rst_cnt;
    xfer(32, 32'hffffffff);
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK("rst_cnt", n0 + 1, rst_cnt)
    `CHK("cont_rst", 1'b0, cont_active_q)
    xfer(16, 32'h1000);
    `CHK("status", rd_data[7:0], rx_word_q[7:0])
    $display("test ones reset done");
    xfer(8, 32'h21);
    @(posedge clk_sys);
    #1 rst_b = 1'b0;
    @(posedge clk_sys);
    #1 rst_b = 1'b1;
    `CHK("rst_idle", 1'b0, cont_active_q)
    seed = lfsr(seed);
    rd_data = {8'h00, seed};
    xfer(16, 32'h1000);
    `CHK("rst_stat", rd_data[7:0], rx_word_q[7:0])
    $display("test mid reset done");
    end_sim();
  end
endmodule : serial_command_register_decoder_bench
